// ### hdl/afc_clock_recovery_config.sv
// Configuration bank for AFC timing and the bit clock recovery loop gears
// Notes on behaviour
// - Pre-preamble AFC waits (short_wait+1)x2 bit periods
// - Short wait zero blocks AFC before preamble
// - Antenna switch wait counts received bit periods
// - Before preamble gain is gain over 2^fast
// - Preamble shifts gain to gain over 2^slow
// - Oversampling ratio 11 bits, three fractional bits
// - Oversampling resets to 12.5 cycles per bit
// - NCO offset is 20 bits over three registers
// - Offset-high bit 4 is loop stall control
// - Timing loop gain is 11 bits
// - Reset values give 40 kbps, no Manchester
// - Manchester enable bit doubles effective rate
// - Third decimator bypass changes loop sample rate
//
// Our own choice: the strobed register port.
`timescale 1ns/1ps
module afc_clock_recovery_config (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rstn,
    // Register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    // Modem events, same clock
    input  wire logic        bit_tick,
    input  wire logic        preamble_detected,
    input  wire logic        search_restart,
    input  wire logic        afc_correction_done,
    input  wire logic        antenna_switch,
    // Loop and AFC controls
    output logic             afc_permit,
    output logic             antenna_settled,
    output logic [10:0]      loop_gain,
    output logic             gear_slow,
    output logic [10:0]      oversampling_ratio,
    output logic [19:0]      nco_offset,
    output logic             loop_stall_control,
    output logic             direct_mode_noise_immunity,
    output logic             manchester_enable,
    output logic             third_decimator_bypass,
    output logic [2:0]       decimation_exponent
);
    localparam int IDX_W = $clog2(afc_recovery_pkg::BANK_WORDS);
    // ----------------------------------------------------------------
    // Address decode, shared by write and read paths
    // ----------------------------------------------------------------
    function automatic logic [IDX_W:0] bank_index(input logic [7:0] addr);
        logic [7:0] rel;
        rel = addr - afc_recovery_pkg::ADDR_AFC_TIMING;
        if (addr >= afc_recovery_pkg::ADDR_AFC_TIMING
            && addr <= afc_recovery_pkg::ADDR_GAIN_LOW)
            bank_index = {1'b1, rel[IDX_W-1:0]};
        else
            bank_index = '0;
    endfunction
    // Bank storage and its field views
    logic [63:0] words;
    logic [7:0]  afc_timing;
    logic [7:0]  gearshift;
    logic [2:0]  short_wait;        // Zero turns pre-preamble AFC off
    logic [2:0]  antenna_switch_wait;
    logic [2:0]  fast_gear_exponent;
    logic [2:0]  slow_gear_exponent;
    logic [10:0] timing_loop_gain;
    logic [IDX_W:0] wr_hit;
    assign wr_hit = bank_index(reg_addr);
    config_store #(
        .WORDS (afc_recovery_pkg::BANK_WORDS),
        .WIDTH (afc_recovery_pkg::DATA_W),
        .RESET (afc_recovery_pkg::BANK_RESET),
        .WMASK (afc_recovery_pkg::BANK_WMASK)
    ) u_store (
        .clk     (clk),
        .rstn    (rstn),
        .wr_en   (reg_wr && wr_hit[IDX_W]),
        .wr_idx  (wr_hit[IDX_W-1:0]),
        .wr_data (reg_wdata),
        .words   (words)
    );
    assign afc_timing = words[afc_recovery_pkg::IDX_AFC_TIMING*8 +: 8];
    assign gearshift  = words[afc_recovery_pkg::IDX_GEARSHIFT*8 +: 8];
    assign short_wait = afc_timing[afc_recovery_pkg::SHWAIT_LSB +: 3];
    assign antenna_switch_wait = afc_timing[afc_recovery_pkg::ANWAIT_LSB +: 3];
    assign fast_gear_exponent  = gearshift[afc_recovery_pkg::FAST_LSB +: 3];
    assign slow_gear_exponent  = gearshift[afc_recovery_pkg::SLOW_LSB +: 3];
    assign timing_loop_gain = {
        words[afc_recovery_pkg::IDX_GAIN_HIGH*8 + afc_recovery_pkg::GAIN_HIGH_LSB +: 3],
        words[afc_recovery_pkg::IDX_GAIN_LOW*8 +: 8]};

    // ----------------------------------------------------------------
    // Static loop settings, wired from the bank flip-flops
    // ----------------------------------------------------------------
    assign oversampling_ratio = {
        words[afc_recovery_pkg::IDX_OFFSET_HIGH*8 + afc_recovery_pkg::OSR_HIGH_LSB +: 3],
        words[afc_recovery_pkg::IDX_OSR_LOW*8 +: 8]};
    assign nco_offset = {
        words[afc_recovery_pkg::IDX_OFFSET_HIGH*8 + afc_recovery_pkg::NCO_HIGH_LSB +: 4],
        words[afc_recovery_pkg::IDX_OFFSET_MID*8 +: 8],
        words[afc_recovery_pkg::IDX_OFFSET_LOW*8 +: 8]};
    assign loop_stall_control =
        words[afc_recovery_pkg::IDX_OFFSET_HIGH*8 + afc_recovery_pkg::STALL_BIT];
    // Software alone decides this bit; the block only carries it out
    assign direct_mode_noise_immunity = gearshift[afc_recovery_pkg::NOISE_IMM_BIT];

    // ----------------------------------------------------------------
    // Mode register: Manchester, decimator bypass, decimation exponent
    // ----------------------------------------------------------------
    logic [7:0] mode_r;
    logic [7:0] mode_nxt;
    always_comb
    begin
        mode_nxt = mode_r;
        if (reg_wr && reg_addr == afc_recovery_pkg::ADDR_MODE)
            mode_nxt = reg_wdata;
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            mode_r <= afc_recovery_pkg::RST_MODE;
        else
            mode_r <= mode_nxt;
    end
    assign manchester_enable      = mode_r[afc_recovery_pkg::MANCH_BIT];
    assign third_decimator_bypass = mode_r[afc_recovery_pkg::BYPASS_BIT];
    assign decimation_exponent    = mode_r[afc_recovery_pkg::DECEXP_LSB +: 3];

    // ----------------------------------------------------------------
    // Gear state and registered loop gain
    // ----------------------------------------------------------------
    afc_recovery_pkg::gear_t gear_r;
    afc_recovery_pkg::gear_t gear_nxt;
    logic [10:0] loop_gain_r;
    logic [10:0] loop_gain_nxt;

    always_comb
    begin
        gear_nxt = gear_r;
        case (gear_r)
            afc_recovery_pkg::GEAR_FAST:
            begin
                // Restart wins so a stale detect cannot hold the slow gear
                if (preamble_detected && !search_restart)
                    gear_nxt = afc_recovery_pkg::GEAR_SLOW;
            end
            afc_recovery_pkg::GEAR_SLOW:
            begin
                if (search_restart)
                    gear_nxt = afc_recovery_pkg::GEAR_FAST;
            end
            default:
                gear_nxt = afc_recovery_pkg::GEAR_FAST;
        endcase
        if (gear_r == afc_recovery_pkg::GEAR_SLOW)
            loop_gain_nxt = timing_loop_gain >> slow_gear_exponent;
        else
            loop_gain_nxt = timing_loop_gain >> fast_gear_exponent;
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            gear_r      <= afc_recovery_pkg::GEAR_FAST;
            loop_gain_r <= '0;
        end
        else
        begin
            gear_r      <= gear_nxt;
            loop_gain_r <= loop_gain_nxt;
        end
    end

    assign gear_slow = (gear_r == afc_recovery_pkg::GEAR_SLOW);
    assign loop_gain = loop_gain_r;

    // ----------------------------------------------------------------
    // AFC wait: counts bit ticks after each correction
    // ----------------------------------------------------------------
    logic [4:0] afc_wait_r;     // Remaining bit periods, 16 at most
    logic [4:0] afc_wait_nxt;
    logic       afc_permit_r;
    logic       afc_permit_nxt;
    always_comb
    begin
        afc_wait_nxt = afc_wait_r;
        if (gear_nxt == afc_recovery_pkg::GEAR_SLOW)
            afc_wait_nxt = '0;
        else if (afc_correction_done)
            afc_wait_nxt = 5'((short_wait + afc_recovery_pkg::AFC_WAIT_ADD)
                * afc_recovery_pkg::AFC_WAIT_UNIT);
        else if (bit_tick && afc_wait_r != '0)
            afc_wait_nxt = afc_wait_r - 5'h01;
        // After the preamble the short wait no longer applies
        if (gear_nxt == afc_recovery_pkg::GEAR_SLOW)
            afc_permit_nxt = 1'b1;
        else
            afc_permit_nxt = (short_wait != '0) && (afc_wait_nxt == '0);
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            afc_wait_r   <= '0;
            afc_permit_r <= 1'b0;
        end
        else
        begin
            afc_wait_r   <= afc_wait_nxt;
            afc_permit_r <= afc_permit_nxt;
        end
    end
    assign afc_permit = afc_permit_r;

    // ----------------------------------------------------------------
    // Antenna switching wait
    // ----------------------------------------------------------------
    logic [2:0] ant_wait_r;
    logic [2:0] ant_wait_nxt;
    logic       ant_settled_r;
    logic       ant_settled_nxt;
    always_comb
    begin
        ant_wait_nxt = ant_wait_r;
        if (antenna_switch)
            ant_wait_nxt = antenna_switch_wait;
        else if (bit_tick && ant_wait_r != '0)
            ant_wait_nxt = ant_wait_r - 3'h1;
        ant_settled_nxt = (ant_wait_nxt == '0);
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ant_wait_r    <= '0;
            ant_settled_r <= 1'b1;
        end
        else
        begin
            ant_wait_r    <= ant_wait_nxt;
            ant_settled_r <= ant_settled_nxt;
        end
    end
    assign antenna_settled = ant_settled_r;

    // ----------------------------------------------------------------
    // Read path: data valid the cycle after the strobe, zero elsewhere
    // ----------------------------------------------------------------
    logic [7:0]     rdata_r;
    logic [7:0]     rdata_nxt;
    logic [IDX_W:0] rd_hit;
    always_comb
    begin
        rd_hit    = bank_index(reg_addr);
        rdata_nxt = '0;     // Idle cycles and unmapped reads give zero
        if (reg_rd && rd_hit[IDX_W])
            rdata_nxt = words[rd_hit[IDX_W-1:0]*8 +: 8];
        else if (reg_rd && reg_addr == afc_recovery_pkg::ADDR_MODE)
            rdata_nxt = mode_r;
        else if (reg_rd && reg_addr == afc_recovery_pkg::ADDR_STATUS)
        begin
            rdata_nxt[afc_recovery_pkg::ST_SLOW_BIT]   = gear_slow;
            rdata_nxt[afc_recovery_pkg::ST_PERMIT_BIT] = afc_permit_r;
            rdata_nxt[afc_recovery_pkg::ST_ANT_BIT]    = ant_settled_r;
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            rdata_r <= '0;
        else
            rdata_r <= rdata_nxt;
    end
    assign reg_rdata = rdata_r;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    property p_gear_up;
        preamble_detected && !search_restart |=> gear_slow;
    endproperty
    a_gear_up: assert property (p_gear_up) else $error("no slow gear");
    property p_gear_back;
        search_restart |=> !gear_slow;
    endproperty
    a_gear_back: assert property (p_gear_back) else $error("no fast gear");
    property p_fast_gain;
        rstn && !gear_slow |=>     // The release edge itself still loads the reset gain
            loop_gain == ($past(timing_loop_gain) >> $past(fast_gear_exponent));
    endproperty
    a_fast_gain: assert property (p_fast_gain) else $error("fast gain wrong");
    property p_slow_gain;
        gear_slow |=> loop_gain == ($past(timing_loop_gain) >> $past(slow_gear_exponent));
    endproperty
    a_slow_gain: assert property (p_slow_gain) else $error("slow gain wrong");
    property p_afc_off;
        short_wait == '0 && !gear_slow && !preamble_detected |=> !afc_permit;
    endproperty
    a_afc_off: assert property (p_afc_off) else $error("afc not disabled");
    property p_afc_hold;
        afc_correction_done && !gear_slow && !preamble_detected && !bit_tick
            ##1 !preamble_detected && !bit_tick |=> !afc_permit;
    endproperty
    a_afc_hold: assert property (p_afc_hold) else $error("afc wait skipped");
    property p_afc_load;
        afc_correction_done && !gear_slow && !preamble_detected |=>
            afc_wait_r == 5'(($past(short_wait) + afc_recovery_pkg::AFC_WAIT_ADD)
            * afc_recovery_pkg::AFC_WAIT_UNIT);
    endproperty
    a_afc_load: assert property (p_afc_load) else $error("afc wait length");
    property p_ant_wait;
        antenna_switch && antenna_switch_wait != '0 |=> !antenna_settled;
    endproperty
    a_ant_wait: assert property (p_ant_wait) else $error("antenna wait");
    property p_read_zero;
        !reg_rd |=> reg_rdata == '0;
    endproperty
    a_read_zero: assert property (p_read_zero) else $error("stray read data");
    c_slow: cover property (preamble_detected ##1 gear_slow);
    c_permit: cover property (afc_correction_done ##[1:40] $rose(afc_permit));
    c_ant: cover property (antenna_switch ##[1:40] $rose(antenna_settled));

endmodule

// ### hdl/afc_recovery_pkg.sv
// Register map, field layout and reset values of the AFC and clock recovery bank
package afc_recovery_pkg;

    // ----------------------------------------------------------------
    // Bus widths
    // ----------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam logic [ADDR_W-1:0] ADDR_AFC_TIMING  = 8'h1e;
    localparam logic [ADDR_W-1:0] ADDR_GEARSHIFT   = 8'h1f;
    localparam logic [ADDR_W-1:0] ADDR_OSR_LOW     = 8'h20;
    localparam logic [ADDR_W-1:0] ADDR_OFFSET_HIGH = 8'h21;
    localparam logic [ADDR_W-1:0] ADDR_OFFSET_MID  = 8'h22;
    localparam logic [ADDR_W-1:0] ADDR_OFFSET_LOW  = 8'h23;
    localparam logic [ADDR_W-1:0] ADDR_GAIN_HIGH   = 8'h24;
    localparam logic [ADDR_W-1:0] ADDR_GAIN_LOW    = 8'h25;
    localparam logic [ADDR_W-1:0] ADDR_MODE        = 8'h2f;
    localparam logic [ADDR_W-1:0] ADDR_STATUS      = 8'h3f;

    // ----------------------------------------------------------------
    // Bank word indices (offset minus first offset)
    // ----------------------------------------------------------------
    localparam int BANK_WORDS       = 8;
    localparam int IDX_AFC_TIMING   = 0;
    localparam int IDX_GEARSHIFT    = 1;
    localparam int IDX_OSR_LOW      = 2;
    localparam int IDX_OFFSET_HIGH  = 3;
    localparam int IDX_OFFSET_MID   = 4;
    localparam int IDX_OFFSET_LOW   = 5;
    localparam int IDX_GAIN_HIGH    = 6;
    localparam int IDX_GAIN_LOW     = 7;

    // ----------------------------------------------------------------
    // Reset values; together they give 40 kbps without Manchester
    // ----------------------------------------------------------------
    localparam logic [DATA_W-1:0] RST_AFC_TIMING  = 8'h0a;
    localparam logic [DATA_W-1:0] RST_GEARSHIFT   = 8'h03;
    localparam logic [DATA_W-1:0] RST_OSR_LOW     = 8'h64;
    localparam logic [DATA_W-1:0] RST_OFFSET_HIGH = 8'h01;
    localparam logic [DATA_W-1:0] RST_OFFSET_MID  = 8'h47;
    localparam logic [DATA_W-1:0] RST_OFFSET_LOW  = 8'hae;
    localparam logic [DATA_W-1:0] RST_GAIN_HIGH   = 8'h02;
    localparam logic [DATA_W-1:0] RST_GAIN_LOW    = 8'h91;
    localparam logic [DATA_W-1:0] RST_MODE        = 8'h00;
    localparam logic [BANK_WORDS*DATA_W-1:0] BANK_RESET = {RST_GAIN_LOW, RST_GAIN_HIGH,
        RST_OFFSET_LOW, RST_OFFSET_MID, RST_OFFSET_HIGH, RST_OSR_LOW, RST_GEARSHIFT,
        RST_AFC_TIMING};
    // Top two bits of the AFC timing word are read-only zero
    localparam logic [BANK_WORDS*DATA_W-1:0] BANK_WMASK = 64'hffffffffffffff3f;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int SHWAIT_LSB    = 3;
    localparam int ANWAIT_LSB    = 0;
    localparam int NOISE_IMM_BIT = 6;
    localparam int FAST_LSB      = 3;
    localparam int SLOW_LSB      = 0;
    localparam int OSR_HIGH_LSB  = 5;
    localparam int STALL_BIT     = 4;
    localparam int NCO_HIGH_LSB  = 0;
    localparam int GAIN_HIGH_LSB = 0;
    localparam int MANCH_BIT     = 0;
    localparam int BYPASS_BIT    = 1;
    localparam int DECEXP_LSB    = 2;
    localparam int ST_SLOW_BIT   = 0;
    localparam int ST_PERMIT_BIT = 1;
    localparam int ST_ANT_BIT    = 2;

    // ----------------------------------------------------------------
    // Timing: short wait is (value + 1) x 2 bit periods
    // ----------------------------------------------------------------
    localparam int AFC_WAIT_UNIT = 2;
    localparam int AFC_WAIT_ADD  = 1;

    // Loop gain gears
    typedef enum logic {GEAR_FAST, GEAR_SLOW} gear_t;

endpackage

// ### hdl/config_store.sv
// Small register store with per-word reset values and write masks
`timescale 1ns/1ps
module config_store #(
    parameter int                       WORDS = 8,
    parameter int                       WIDTH = 8,
    parameter logic [WORDS*WIDTH-1:0]   RESET = '0,
    parameter logic [WORDS*WIDTH-1:0]   WMASK = '1
) (
    // Clock and reset
    input  wire logic                     clk,
    input  wire logic                     rstn,
    // Write port
    input  wire logic                     wr_en,
    input  wire logic [$clog2(WORDS)-1:0] wr_idx,
    input  wire logic [WIDTH-1:0]         wr_data,
    // Every word, straight from its flip-flops
    output logic      [WORDS*WIDTH-1:0]   words
);

    // Storage and its next value
    logic [WORDS*WIDTH-1:0] store_r;
    logic [WORDS*WIDTH-1:0] store_nxt;

    // The write index needs at least one bit; refuse a store it cannot address
    if (WORDS < 2 || WIDTH < 1)
    begin
        $error("config_store needs two or more words of one or more bits");
    end

    // ----------------------------------------------------------------
    // Next value: only the addressed word, only its writable bits
    // ----------------------------------------------------------------
    always_comb
    begin
        store_nxt = store_r;
        for (int i = 0; i < WORDS; i++)
        begin
            if (wr_en && wr_idx == i[$clog2(WORDS)-1:0])
            begin
                store_nxt[i*WIDTH +: WIDTH] = (wr_data & WMASK[i*WIDTH +: WIDTH])
                    | (store_r[i*WIDTH +: WIDTH] & ~WMASK[i*WIDTH +: WIDTH]);
            end
        end
    end

    // Registers
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            store_r <= RESET;
        else
            store_r <= store_nxt;
    end

    assign words = store_r;

endmodule

// ### test/tb_top.sv
// Self-checking bench for the AFC timing and clock recovery configuration bank
`timescale 1ns/1ps
module tb_top;

    // ------------------------------------------------------------
    // Stimulus and observation
    // ------------------------------------------------------------
    logic        clk;          // 25 MHz clock
    logic        rstn;         // Active-low reset
    logic [7:0]  reg_addr;     // Register address
    logic [7:0]  reg_wdata;    // Write data
    logic        reg_wr;       // Write strobe
    logic        reg_rd;       // Read strobe
    logic [7:0]  reg_rdata;    // Read data
    logic [4:0]  ev;           // Events: tick, preamble, restart, correction, switch
    logic        afc_permit;
    logic        antenna_settled;
    logic [10:0] loop_gain;
    logic        gear_slow;
    logic [10:0] oversampling_ratio;
    logic [19:0] nco_offset;
    logic        loop_stall_control;
    logic        direct_mode_noise_immunity;
    logic        manchester_enable;
    logic        third_decimator_bypass;
    logic [2:0]  decimation_exponent;
    int          failures;     // Mismatches seen
    int          checks_done;  // Comparisons made
    logic [7:0]  rd_val;       // Last value read
    // Register reset values, offsets 0x1e to 0x25
    logic [7:0]  rst_tab [8] = '{8'h0a, 8'h03, 8'h64, 8'h01, 8'h47, 8'hae, 8'h02, 8'h91};

    afc_clock_recovery_config dut (
        .clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .bit_tick(ev[0]), .preamble_detected(ev[1]), .search_restart(ev[2]),
        .afc_correction_done(ev[3]), .antenna_switch(ev[4]),
        .afc_permit(afc_permit), .antenna_settled(antenna_settled),
        .loop_gain(loop_gain), .gear_slow(gear_slow),
        .oversampling_ratio(oversampling_ratio), .nco_offset(nco_offset),
        .loop_stall_control(loop_stall_control),
        .direct_mode_noise_immunity(direct_mode_noise_immunity),
        .manchester_enable(manchester_enable),
        .third_decimator_bypass(third_decimator_bypass),
        .decimation_exponent(decimation_exponent)
    );

    // ------------------------------------------------------------
    // Clock, checks and bus tasks
    // ------------------------------------------------------------
    always #20 clk = ~clk;

    // One comparison; four-state equality so an unknown matches only an unknown
    task automatic chk(input logic [19:0] got, input logic [19:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            failures++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Strobes are one cycle; the result is looked at just after the taking edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        rd_val = reg_rdata;
    endtask

    // One-cycle event pulse on the chosen inputs
    task automatic pulse(input logic [4:0] m);
        @(posedge clk);
        ev <= m;
        @(posedge clk);
        ev <= 5'h00;
        #1;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Watchdog: the sequence needs about 120 cycles
    // ------------------------------------------------------------
    initial
    begin
        #(40 * 5000);
        failures++;
        print_verdict();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        rstn = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        ev = 5'h00;
        failures = 0;
        checks_done = 0;
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        cyc(2);
        // Reset contents and the fields built from them
        for (int i = 0; i < 8; i++)
        begin
            rd(8'h1e + 8'(i));
            chk(rd_val, rst_tab[i]);
        end
        cyc(1);
        chk(reg_rdata, 8'h00);
        chk(oversampling_ratio, 11'h064);
        chk(nco_offset, 20'h147ae);
        chk(loop_gain, 11'h291);
        // Antenna wait of two bit periods
        pulse(5'h10);
        chk(antenna_settled, 1'b0);
        pulse(5'h01);
        chk(antenna_settled, 1'b0);
        pulse(5'h01);
        cyc(1);
        chk(antenna_settled, 1'b1);
        // Short wait of (1+1)x2 = 4 bit periods after a correction
        chk(afc_permit, 1'b1);
        pulse(5'h08);
        chk(afc_permit, 1'b0);
        repeat (3) pulse(5'h01);
        chk(afc_permit, 1'b0);
        pulse(5'h01);
        cyc(1);
        chk(afc_permit, 1'b1);
        // Reserved top bits read zero; short wait zero blocks correction
        wr(8'h1e, 8'hc2);
        rd(8'h1e);
        chk(rd_val, 8'h02);
        pulse(5'h08);
        repeat (10) pulse(5'h01);
        chk(afc_permit, 1'b0);
        // Gear shift: fast 1, slow 5, timing gain 0x7ff
        wr(8'h24, 8'h07);
        wr(8'h25, 8'hff);
        wr(8'h1f, 8'h4d);
        cyc(1);
        chk(loop_gain, 11'h3ff);
        chk(direct_mode_noise_immunity, 1'b1);
        pulse(5'h06);
        chk(gear_slow, 1'b0);
        pulse(5'h02);
        chk(gear_slow, 1'b1);
        cyc(1);
        chk(loop_gain, 11'h03f);
        rd(8'h3f);
        chk(rd_val, 8'h07);
        pulse(5'h04);
        chk(gear_slow, 1'b0);
        cyc(1);
        chk(loop_gain, 11'h3ff);
        wr(8'h1f, 8'h05);
        chk(direct_mode_noise_immunity, 1'b0);
        // Split fields across the offset-high register
        wr(8'h21, 8'hb5);
        chk(oversampling_ratio, 11'h564);
        chk(loop_stall_control, 1'b1);
        chk(nco_offset, 20'h547ae);
        wr(8'h21, 8'h00);
        chk(loop_stall_control, 1'b0);
        rd(8'h24);
        chk(rd_val, 8'h07);
        // Mode register fields
        wr(8'h2f, 8'h1d);
        chk(manchester_enable, 1'b1);
        chk(third_decimator_bypass, 1'b0);
        chk(decimation_exponent, 3'h7);
        wr(8'h2f, 8'h02);
        chk(manchester_enable, 1'b0);
        chk(third_decimator_bypass, 1'b1);
        // Unmapped address: write ignored, read zero
        wr(8'h40, 8'h5a);
        rd(8'h40);
        chk(rd_val, 8'h00);
        rd(8'h20);
        chk(rd_val, 8'h64);
        // Bypass now set: host rewrites ratio, offset and gain for 40 kbps
        wr(8'h21, 8'h20);
        wr(8'h20, 8'h2c);
        wr(8'h22, 8'h6d);
        wr(8'h23, 8'h3a);
        wr(8'h24, 8'h00);
        wr(8'h25, 8'hdc);
        chk(oversampling_ratio, 11'h12c);
        chk(oversampling_ratio >= 11'h040, 1'b1);
        chk(nco_offset, 20'h06d3a);
        cyc(1);
        chk(loop_gain, 11'h0dc);
        print_verdict();
    end

endmodule
